// *** logic/prd_decode.sv ***
// Processor register decoder: routes register moves to the processor chip
// bank, the cache controller bank, or out as an external register cycle.
// Assumes one request at a time from the core, held until o_done.
`timescale 1ns/10ps

// Overview of operation
// - Unimplemented numbers go out as bus cycles
// - External cycle ends after programmed timeout
// - Stall core and bus during timeout
// - Flagged registers initialise on reset
// - Backup cache error register is read-only
// - Flush registers write-only, write triggers flush
// - Vector error status lives in cache chip
// - Category 1 standard, category 2 specific
// - Primary cache registers 7c-7f read/write
// - Backup cache registers 74-77 read/write
module prd_decode (
    // Clock and reset (reset is power-up or power-good loss)
    input wire logic i_clk,
    input wire logic i_nrst,
    // Register move from the core
    input wire prd_pkg::prd_req_t i_req,
    output logic o_done,
    output logic [31:0] o_rdata,
    output logic o_stall,
    // Bus timeout setting, in microseconds
    input wire logic [31:0] i_tmo_us,
    // External register cycle
    output prd_pkg::prd_ext_t o_ext,
    // Error capture from the caches
    input wire logic i_bc_err_set,
    input wire logic [31:0] i_bc_err_val,
    // Flush strobes to the backup cache
    output logic o_flush_bt,
    output logic o_flush_pt
);
    import prd_pkg::*;

    // Idle takes a request; wait sits out the bus timeout; answer frees the core
    typedef enum logic [1:0] {
        PRD_IDLE,
        PRD_WAIT,
        PRD_ANSWER
    } prd_state_t;

    prd_state_t state; // Sequencer state
    logic [31:0] bank [PRD_BANK_N]; // Local register storage
    logic [31:0] bc_error; // Captured backup cache error
    logic [31:0] tmo_cycles; // Timeout limit in clock cycles
    logic expired; // Timeout finished this cycle
    logic start_ext; // Launch an external cycle
    logic [7:0] rel; // Number relative to bank base
    logic in_bank; // Number falls in the local bank
    logic take; // Request accepted this cycle
    logic [31:0] next_rdata; // Read value of the addressed register

    // Decode the number; anything outside 73-7f is not held here
    always_comb begin
        rel = i_req.num - PRD_BANK_BASE;
        in_bank = (i_req.num >= PRD_N_BC_P2_TAG) && (i_req.num <= PRD_N_PC_STATUS);
    end

    assign take = i_req.valid && (state == PRD_IDLE);
    assign start_ext = take && !in_bank;
    // Product stays well inside 32 bits for any sane microsecond value
    assign tmo_cycles = i_tmo_us * PRD_CLK_MHZ;

    // Timeout counter that ends a forwarded cycle
    // A setting of zero still waits one counted cycle before the answer
    prd_timeout u_tmo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_start(start_ext),
        .i_limit(tmo_cycles),
        .o_expired(expired)
    );

    // Read mux; write-only numbers read as zero
    // The error number is served from bc_error; its bank slot never changes
    always_comb begin
        next_rdata = PRD_ZERO;
        if (i_req.num == PRD_N_BC_ERROR) begin
            next_rdata = bc_error;
        end else if (i_req.num == PRD_N_BC_FLUSH_BT || i_req.num == PRD_N_BC_FLUSH_PT) begin
            next_rdata = PRD_ZERO;
        end else if (in_bank) begin
            next_rdata = bank[rel[3:0]];
        end
    end

    // Sequencer: local numbers answer next cycle, external ones wait out timeout
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= PRD_IDLE;
        end else begin
            unique case (state)
                PRD_IDLE: begin
                    if (take && in_bank) begin
                        state <= PRD_ANSWER;
                    end else if (start_ext) begin
                        state <= PRD_WAIT;
                    end
                end
                PRD_WAIT: begin
                    // Only the timeout ends a forwarded cycle
                    if (expired) begin
                        state <= PRD_ANSWER;
                    end
                end
                PRD_ANSWER: begin
                    state <= PRD_IDLE;
                end
            endcase
        end
    end

    // Answer to the core; external cycles return zero on timeout
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_done <= 1'b0;
            o_rdata <= PRD_ZERO;
        end else begin
            o_done <= 1'b0;
            if (take && in_bank) begin
                o_done <= 1'b1;
                o_rdata <= i_req.write ? PRD_ZERO : next_rdata;
            end else if (state == PRD_WAIT && expired) begin
                o_done <= 1'b1;
                o_rdata <= PRD_ZERO;
            end
        end
    end

    // Stall holds the core for the whole external cycle
    // Raised with the forwarded cycle and lowered with its answer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stall <= 1'b0;
        end else begin
            o_stall <= start_ext || (state == PRD_WAIT && !expired);
        end
    end

    // External cycle drive; no other cycle may start while active
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ext <= '0;
        end else begin
            if (start_ext) begin
                o_ext.active <= 1'b1;
                o_ext.write <= i_req.write;
                o_ext.num <= i_req.num;
                o_ext.wdata <= i_req.wdata;
            end else if (state == PRD_WAIT && expired) begin
                o_ext <= '0;
            end
        end
    end

    // Flush strobes: one-cycle pulse per write to a flush number
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flush_bt <= 1'b0;
            o_flush_pt <= 1'b0;
        end else begin
            o_flush_bt <= take && i_req.write && (i_req.num == PRD_N_BC_FLUSH_BT);
            o_flush_pt <= take && i_req.write && (i_req.num == PRD_N_BC_FLUSH_PT);
        end
    end

    // Error register is loaded only by the cache, never by a write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bc_error <= PRD_ZERO;
        end else if (i_bc_err_set) begin
            bc_error <= i_bc_err_val;
        end
    end

    // Read/write bank, one generate entry per register number
    // Entries for 78-7a are never written; their storage goes unused
    generate
        for (genvar gi = 0; gi < PRD_BANK_N; gi++) begin : g_bank
            localparam logic [7:0] NUM = PRD_BANK_BASE + 8'(gi);
            localparam bit IS_RW = (NUM != PRD_N_BC_ERROR) && (NUM != PRD_N_BC_FLUSH_BT)
                && (NUM != PRD_N_BC_FLUSH_PT);
            localparam logic [31:0] RST = (NUM == PRD_N_BC_STATUS) ? PRD_RST_BC_STATUS :
                (NUM == PRD_N_BC_CONTROL) ? PRD_RST_BC_CONTROL :
                (NUM == PRD_N_PC_STATUS) ? PRD_RST_PC_STATUS : PRD_ZERO;
            // Flagged entries start defined; others simply clear too
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    bank[gi] <= RST;
                end else if (IS_RW && take && i_req.write && i_req.num == NUM) begin
                    bank[gi] <= i_req.wdata;
                end
            end
            // Each read/write entry must hold the word just written to it
            if (IS_RW) begin : g_rw_chk
                chk_entry_store: assert property (
                    @(posedge i_clk) disable iff (!i_nrst)
                    (take && i_req.write && i_req.num == NUM)
                        |=> bank[gi] == $past(i_req.wdata)
                ) else $error("Read/write entry lost a write");
            end
        end
    endgenerate

    // Software is expected to avoid unimplemented numbers; the stall is long

    // Helper: cycles spent waiting in the current external cycle
    // Cleared whenever the sequencer leaves the wait state
    logic [31:0] wait_cnt;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_cnt <= PRD_ZERO;
        end else if (state == PRD_WAIT) begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
        end else begin
            wait_cnt <= PRD_ZERO;
        end
    end

    // Checks on the answer path, the forwarded cycle and the register bank
    // The wait count above exists only to time the forwarded cycle
    chk_local_done: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && in_bank) |=> o_done && !o_stall
    ) else $error("Local register access did not complete next cycle");

    chk_ext_start: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        start_ext |=> o_ext.active && o_ext.num == $past(i_req.num) && o_stall
    ) else $error("Unimplemented number not forwarded");

    chk_ext_no_early: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state == PRD_WAIT && expired) |-> (wait_cnt >= tmo_cycles)
    ) else $error("External cycle ended before timeout");

    chk_stall_hold: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state == PRD_WAIT && !expired) |=> o_stall && o_ext.active
    ) else $error("Stall dropped during external cycle");

    chk_error_ro: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (!i_bc_err_set) |=> bc_error == $past(bc_error)
    ) else $error("Backup cache error register changed by write");

    chk_flush_pulse: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && i_req.write && i_req.num == PRD_N_BC_FLUSH_PT) |=> o_flush_pt ##1 !o_flush_pt
    ) else $error("Primary tag flush did not pulse once");

    chk_rw_store: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && i_req.write && i_req.num == PRD_N_PC_STATUS) |=> bank[12] == $past(i_req.wdata)
    ) else $error("Primary cache status write lost");

    chk_vec_store: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && i_req.write && i_req.num == PRD_N_VEC_ERR) |=> bank[8] == $past(i_req.wdata)
    ) else $error("Vector error status write lost");

    chk_bc_store: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && i_req.write && i_req.num == PRD_N_BC_CONTROL) |=> bank[4] == $past(i_req.wdata)
    ) else $error("Backup cache control write lost");

    // A waiting forwarded cycle keeps its number, direction and data
    chk_ext_hold: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state == PRD_WAIT && !expired) |=> $stable(o_ext)
    ) else $error("Forwarded cycle changed while waiting");

    // No flush strobe is launched while the sequencer is busy
    chk_busy_quiet: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state != PRD_IDLE) |=> !o_flush_bt && !o_flush_pt
    ) else $error("Flush strobed while busy");

    // The answer of a forwarded cycle comes right after the timeout
    chk_ext_end: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state == PRD_WAIT && expired)
            |=> o_done && !o_stall && !o_ext.active && o_rdata == PRD_ZERO
    ) else $error("Forwarded cycle did not end after timeout");

    // Backup tag flush pulses once per write
    chk_flush_bt_pulse: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && i_req.write && i_req.num == PRD_N_BC_FLUSH_BT)
            |=> o_flush_bt ##1 !o_flush_bt
    ) else $error("Backup tag flush did not pulse once");

    // Reading a flush number answers zero and flushes nothing
    chk_flush_read: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && !i_req.write && (i_req.num == PRD_N_BC_FLUSH_BT
            || i_req.num == PRD_N_BC_FLUSH_PT))
            |=> o_done && o_rdata == PRD_ZERO && !o_flush_bt && !o_flush_pt
    ) else $error("Flush number read gave data or flushed");

    // The cache side loads the error register whenever it strobes
    chk_error_load: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_bc_err_set |=> bc_error == $past(i_bc_err_val)
    ) else $error("Backup cache error capture lost");

    // A read of the error number returns the captured value
    chk_error_read: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && !i_req.write && i_req.num == PRD_N_BC_ERROR) |=> o_rdata == $past(bc_error)
    ) else $error("Backup cache error read wrong");

    // The answer strobe lasts one cycle, so one move gives one answer
    chk_done_pulse: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        o_done |=> !o_done
    ) else $error("Answer strobe stood for more than one cycle");

    // Local writes answer with zero data
    chk_write_zero: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && in_bank && i_req.write) |=> o_rdata == PRD_ZERO
    ) else $error("Local write answered with data");

    // A local number never appears on the external bus
    chk_local_no_ext: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (take && in_bank) |=> !o_ext.active
    ) else $error("Local number forwarded externally");

    // Main scenarios worth seeing at least once
    cov_local_read: cover property (@(posedge i_clk) disable iff (!i_nrst)
        take && in_bank && !i_req.write);
    cov_ext_done: cover property (@(posedge i_clk) disable iff (!i_nrst)
        state == PRD_WAIT && expired);
    cov_flush_bt: cover property (@(posedge i_clk) disable iff (!i_nrst) o_flush_bt);
    cov_ext_write: cover property (@(posedge i_clk) disable iff (!i_nrst)
        state == PRD_WAIT && expired && o_ext.write);
    cov_flush_pt: cover property (@(posedge i_clk) disable iff (!i_nrst) o_flush_pt);

endmodule

// *** logic/prd_pkg.sv ***
// Package for the processor register decoder: register numbers, reset
// values, timing constants and the request and forwarded external cycle carriers.
// Assumes a single 25 MHz clock domain and a 32-bit register data path.
package prd_pkg;

    // Register number width (processor register space is 8 bits wide here)
    localparam int PRD_NUM_W = 8;
    localparam int PRD_DATA_W = 32;

    // Implemented register numbers
    localparam logic [7:0] PRD_N_BC_P2_TAG = 8'h73;
    localparam logic [7:0] PRD_N_BC_REFRESH = 8'h74;
    localparam logic [7:0] PRD_N_BC_INDEX = 8'h75;
    localparam logic [7:0] PRD_N_BC_STATUS = 8'h76;
    localparam logic [7:0] PRD_N_BC_CONTROL = 8'h77;
    localparam logic [7:0] PRD_N_BC_ERROR = 8'h78;
    localparam logic [7:0] PRD_N_BC_FLUSH_BT = 8'h79;
    localparam logic [7:0] PRD_N_BC_FLUSH_PT = 8'h7a;
    localparam logic [7:0] PRD_N_VEC_ERR = 8'h7b;
    localparam logic [7:0] PRD_N_PC_TAG = 8'h7c;
    localparam logic [7:0] PRD_N_PC_INDEX = 8'h7d;
    localparam logic [7:0] PRD_N_PC_ERR_ADDR = 8'h7e;
    localparam logic [7:0] PRD_N_PC_STATUS = 8'h7f;

    // Window base and size of the local register bank
    localparam logic [7:0] PRD_BANK_BASE = 8'h73;
    localparam int PRD_BANK_N = 13;

    // Reset values of the registers flagged for initialisation
    localparam logic [31:0] PRD_RST_BC_STATUS = 32'h0000_0000;
    localparam logic [31:0] PRD_RST_BC_CONTROL = 32'h0000_0000;
    localparam logic [31:0] PRD_RST_PC_STATUS = 32'h0000_0000;
    localparam logic [31:0] PRD_ZERO = 32'h0000_0000;

    // Bus timeout: programmed in microseconds, counted in 40 ns cycles
    localparam int PRD_CLK_MHZ = 25;
    localparam logic [31:0] PRD_TMO_US_DEF = 32'h0000_000a;

    // Access category of a register number
    typedef enum logic [1:0] {
        PRD_CAT_PCHIP,
        PRD_CAT_CCHIP,
        PRD_CAT_EXT
    } prd_cat_t;

    // Register move request from the processor core
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] num;
        logic [31:0] wdata;
    } prd_req_t;

    // Forwarded external register cycle on the external data/address bus
    typedef struct packed {
        logic active;
        logic write;
        logic [7:0] num;
        logic [31:0] wdata;
    } prd_ext_t;

endpackage

// *** logic/prd_timeout.sv ***
// Bus timeout counter of the system support chip side of the decoder.
// Assumes the limit holds still while a count runs.
`timescale 1ns/10ps
module prd_timeout (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_start,
    input wire logic [31:0] i_limit,
    // Result
    output logic o_expired
);
    import prd_pkg::*;

    logic [31:0] count; // Cycles left in the current wait
    logic running; // A wait is in progress

    // Load on start, count down, pulse on reaching the last cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= PRD_ZERO;
            running <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_start) begin
                count <= i_limit;
                running <= 1'b1;
            end else if (running) begin
                if (count <= 32'h0000_0001) begin
                    running <= 1'b0;
                    o_expired <= 1'b1;
                end else begin
                    count <= count - 32'h0000_0001;
                end
            end
        end
    end

endmodule

// *** verif/prd_far_model.sv ***
// Far-side model: cache controller error capture, flush and external watch.
// Assumes the decoder's clock and reset; the bench commands error loads.
`timescale 1ns/10ps
module prd_far_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Commands from the bench
    input wire logic i_load,
    input wire logic [31:0] i_val,
    // Decoder outputs watched
    input wire logic i_flush_bt,
    input wire logic i_flush_pt,
    input wire prd_pkg::prd_ext_t i_ext,
    // Error capture towards the decoder
    output logic o_err_set,
    output logic [31:0] o_err_val,
    // Event counts seen
    output logic [7:0] o_bt_cnt,
    output logic [7:0] o_pt_cnt,
    output logic [7:0] o_ext_cnt
);
    import prd_pkg::*;
    logic ext_seen; // Active level one cycle back
    // Error load pulse; value flips when idle so stale data never passes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_err_set <= 1'b0;
            o_err_val <= 32'h0000_0000;
        end else begin
            o_err_set <= i_load;
            o_err_val <= i_load ? i_val : ~o_err_val;
        end
    end
    // Count flush strobes and starts of external cycles
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_seen <= 1'b0;
            o_bt_cnt <= 8'h00;
            o_pt_cnt <= 8'h00;
            o_ext_cnt <= 8'h00;
        end else begin
            ext_seen <= i_ext.active;
            if (i_flush_bt) o_bt_cnt <= o_bt_cnt + 8'h01;
            if (i_flush_pt) o_pt_cnt <= o_pt_cnt + 8'h01;
            if (i_ext.active && !ext_seen) o_ext_cnt <= o_ext_cnt + 8'h01;
        end
    end
endmodule

// *** verif/test_processor_register_decode.sv ***
// Bench for the processor register decoder: register moves, flushes,
// error capture and forwarded external cycles, driven on falling edges.
`timescale 1ns/10ps
module test_processor_register_decode;
    import prd_pkg::*;
    logic clk, nrst, done, stall, err_set, flush_bt, flush_pt, load;
    logic [31:0] rdata, tmo_us, err_val, lval, rd;
    logic [7:0] bt_cnt, pt_cnt, ext_cnt, e0;
    prd_req_t req; // Request held by the access task
    prd_ext_t ext; // Forwarded cycle seen
    int fail_count, checked, cyc, stl, wd_cnt;
    logic [7:0] ext_nums [4] = '{8'h40, 8'h80, 8'h72, 8'hff}; // Outside the bank
    prd_decode i_dut (.i_clk(clk), .i_nrst(nrst), .i_req(req), .o_done(done),
        .o_rdata(rdata), .o_stall(stall), .i_tmo_us(tmo_us), .o_ext(ext),
        .i_bc_err_set(err_set), .i_bc_err_val(err_val), .o_flush_bt(flush_bt),
        .o_flush_pt(flush_pt));
    prd_far_model i_far (.i_clk(clk), .i_nrst(nrst), .i_load(load), .i_val(lval),
        .i_flush_bt(flush_bt), .i_flush_pt(flush_pt), .i_ext(ext), .o_err_set(err_set),
        .o_err_val(err_val), .o_bt_cnt(bt_cnt), .o_pt_cnt(pt_cnt), .o_ext_cnt(ext_cnt));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One register move; counts cycles to o_done and cycles stalled
    task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd);
        @(negedge clk);
        req <= '{valid: 1'b1, write: wr, num: num, wdata: wd};
        cyc = 0;
        stl = 0;
        do begin
            @(negedge clk);
            cyc++;
            if (stall === 1'b1) stl++;
            if (ext.active === 1'b1) check({ext.write, ext.num}, {wr, num});
            if (ext.active === 1'b1 && wr) check(ext.wdata, wd);
        end while (done !== 1'b1 && cyc < 2000);
        check(done, 1'b1);
        rd = rdata;
        req <= '0; // Low in the done cycle, so no repeat take
    endtask
    // Hang guard, far above the expected run length
    initial begin
        wd_cnt = 0;
        forever begin
            @(posedge clk);
            wd_cnt++;
            if (wd_cnt == 20000) begin
                fail_count++;
                final_report();
            end
        end
    end
    initial begin
        nrst = 1'b0;
        req = '0;
        tmo_us = 32'h0000_0001;
        load = 1'b0;
        lval = 32'h0000_0000;
        fail_count = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        @(negedge clk) nrst <= 1'b1;
        // Read/write bank: all written first, then read back to catch aliasing
        for (int n = 8'h73; n <= 8'h7f; n++) begin
            if (n < 8'h78 || n > 8'h7a) access(1'b1, 8'(n), {24'h5ac3e1, 8'(n)});
        end
        for (int n = 8'h73; n <= 8'h7f; n++) begin
            if (n < 8'h78 || n > 8'h7a) begin
                access(1'b0, 8'(n), 32'h0000_0000);
                check(rd, {24'h5ac3e1, 8'(n)});
                check(cyc, 1);
                check(stl, 0);
            end
        end
        $display("test bank read/write done");
        // Second reset mid-run brings flagged registers back to zero
        @(negedge clk) nrst <= 1'b0;
        repeat (2) @(negedge clk);
        nrst <= 1'b1;
        access(1'b0, PRD_N_BC_STATUS, 32'h0);
        check(rd, PRD_RST_BC_STATUS);
        access(1'b0, PRD_N_BC_CONTROL, 32'h0);
        check(rd, PRD_RST_BC_CONTROL);
        access(1'b0, PRD_N_PC_STATUS, 32'h0);
        check(rd, PRD_RST_PC_STATUS);
        $display("test reset values done");
        // Error register: loaded by the cache side, writes from the core ignored
        access(1'b1, PRD_N_BC_ERROR, 32'hffff_ffff);
        access(1'b0, PRD_N_BC_ERROR, 32'h0);
        check(rd, 32'h0000_0000);
        @(negedge clk) load <= 1'b1;
        lval <= 32'h1234_5678;
        @(negedge clk) load <= 1'b0;
        access(1'b1, PRD_N_BC_ERROR, 32'h0bad_0bad);
        access(1'b0, PRD_N_BC_ERROR, 32'h0);
        check(rd, 32'h1234_5678);
        $display("test error register done");
        // Flush registers: each write strobes once, reads give nothing
        access(1'b1, PRD_N_BC_FLUSH_BT, 32'h0000_0001);
        access(1'b1, PRD_N_BC_FLUSH_PT, 32'h0000_0001);
        access(1'b1, PRD_N_BC_FLUSH_PT, 32'h0000_0002);
        access(1'b0, PRD_N_BC_FLUSH_BT, 32'h0);
        check(rd, 32'h0000_0000);
        access(1'b0, PRD_N_BC_FLUSH_PT, 32'h0);
        check(rd, 32'h0000_0000);
        check(bt_cnt, 8'h01);
        check(pt_cnt, 8'h02);
        $display("test flush done");
        // Unimplemented numbers are touched only here, one at a time
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) tmo_us <= 32'(i % 2 + 1);
            e0 = ext_cnt;
            access(1'b1 & i[0], ext_nums[i], 32'hcafe_0000 + 32'(i));
            check(ext_cnt, e0 + 8'h01);
            check(rd, 32'h0000_0000);
            check(stl >= (i % 2 + 1) * PRD_CLK_MHZ, 1);
            check(cyc <= (i % 2 + 1) * PRD_CLK_MHZ + 4, 1);
        end
        access(1'b0, PRD_N_PC_TAG, 32'h0);
        check(cyc, 1);
        $display("test external cycles done");
        final_report();
    end
endmodule
